// ==== shared/glsfe_pkg.sv ====
package glsfe_pkg;
    // ************************************************************
    // widths and counts
    // ************************************************************
    localparam int ADDR_BITS = 5;
    localparam int DATA_BITS = 6;
    localparam int BUS_BITS = 8;
    localparam int CMP_BITS = 7;
    localparam int CHAIN_BYTES = 12;
    localparam int FIFO_DEPTH = 16;
    localparam int STROBE_CYCLES = 2;
    localparam int SYNC_STAGES = 3;
    // ************************************************************
    // values
    // ************************************************************
    localparam logic [6:0] CR_CODE = 7'h0D;
    localparam logic [1:0] PULSE_RST = 2'h0;
endpackage

// ==== shared/glsfe_fifo_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface glsfe_fifo_if #(parameter int WIDTH = 7);
    logic in_valid;
    logic in_ready;
    logic [WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [WIDTH-1:0] out_data;
    modport producer(output in_valid, output in_data, input in_ready,
                     input out_valid, input out_data, output out_ready);
    modport fifo(input in_valid, input in_data, output in_ready,
                 output out_valid, output out_data, input out_ready);
endinterface
`default_nettype wire

// ==== src/glsfe_fifo.sv ====
`timescale 1ns/10ps
`default_nettype none
module glsfe_fifo
    import glsfe_pkg::*;
#(
    parameter int WIDTH = 7,
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // streams
    glsfe_fifo_if.fifo f
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic do_wr;
    logic do_rd;

    assign f.in_ready = (count != (AW+1)'(DEPTH));
    assign f.out_valid = (count != '0);
    assign f.out_data = mem[rd_ptr];
    assign do_wr = f.in_valid && f.in_ready;
    assign do_rd = f.out_valid && f.out_ready;

    always_ff @(posedge CLK) begin
        if (do_wr) begin
            mem[wr_ptr] <= f.in_data;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== src/glsfe_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// RULE1 - listen address comes from five hardware switches, never from the bus
// RULE2 - addressed indicator lit exactly while listening
// RULE3 - negative-logic bus data inverted to positive logic for the chain
// RULE4 - data buffers enabled only while listen_active_n is low
// RULE5 - buffered data drives first chain card and the terminator comparator
// RULE6 - seven buffered bits compared with carriage return flag end of string
// RULE7 - steering high for ordinary bytes selects shift path
// RULE8 - receive strobe sampled by a two-bit shift register on chip clock
// RULE9 - inverted shift register output low acknowledges the byte
// RULE10 - byte strobe lasts two chip clock periods, output as shift when steering high
// RULE11 - carriage return drops steering and routes strobe to load output
// RULE12 - init or clear command asserts active-low chain clear
// RULE13 - controller sends unlisten after each command string
// RULE14 - unlisten deasserts listening, indicator off, buffers disabled
// RULE15 - no panel controls; everything arrives over the bus
// RULE16 - controller sends twelve six-bit bytes then carriage return
// RULE17 - shift moves chain one stage; load copies stages into output latches
// RULE18 - chain clear forces every stage and latch bit to zero
// RULE19 - each byte yields exactly one of shift or load, never both
module glsfe_top
    import glsfe_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // hardware address straps
    input wire logic [ADDR_BITS-1:0] LISTEN_ADDRESS_SWITCHES,
    // instrument bus, negative-logic data lines, active-high command lines
    input wire logic [BUS_BITS-1:0] BUS_DIO_N,
    input wire logic BUS_LISTEN_ADDR,
    input wire logic BUS_UNLISTEN,
    input wire logic BUS_DEVICE_CLEAR,
    input wire logic BUS_BYTE_VALID,
    output logic BUS_BYTE_TAKEN,
    // listener status
    output logic ADDRESSED_INDICATOR,
    output logic LISTEN_ACTIVE_N,
    output logic RX_TRANSFER_DONE,
    // latch chain backplane
    output logic [DATA_BITS-1:0] CHAIN_DATA,
    output logic CHAIN_SHIFT_PULSE,
    output logic LATCH_TRANSFER_PULSE,
    output logic CHAIN_CLEAR_N,
    // relay drive image of the whole chain
    output logic [CHAIN_BYTES*DATA_BITS-1:0] RELAY_DRIVE
);
    // ************************************************************
    // pin synchronisers
    // ************************************************************
    localparam int NSYNC = BUS_BITS + 4;
    // idle bus: negative-logic data lines high, command lines low
    localparam logic [NSYNC-1:0] PIN_IDLE = {{BUS_BITS{1'b1}}, 4'h0};
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] s1, s2, s3;
    logic [NSYNC-1:0] pin_q;
    assign pin_raw = {BUS_DIO_N, BUS_LISTEN_ADDR, BUS_UNLISTEN, BUS_DEVICE_CLEAR,
                      BUS_BYTE_VALID};

    always_ff @(posedge CLK) begin
        // stages reset to the idle level, so release shows no false edge
        if (SRST) begin
            s1 <= PIN_IDLE;
            s2 <= PIN_IDLE;
            s3 <= PIN_IDLE;
        end else begin
            s1 <= pin_raw;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // a change counts only once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_agree
            always_ff @(posedge CLK) begin
                if (SRST) begin
                    pin_q[gi] <= PIN_IDLE[gi];
                end else if (s2[gi] == s3[gi]) begin
                    pin_q[gi] <= s3[gi];
                end
            end
        end
    endgenerate

    logic [BUS_BITS-1:0] dio_n;
    logic listen_cmd, unlisten_cmd, clear_cmd, byte_valid;
    assign dio_n = pin_q[NSYNC-1:4];
    assign listen_cmd = pin_q[3];
    assign unlisten_cmd = pin_q[2];
    assign clear_cmd = pin_q[1];
    assign byte_valid = pin_q[0];

    // ************************************************************
    // address capture and listen state
    // ************************************************************
    logic [ADDR_BITS-1:0] my_addr;
    logic listening;

    // straps are sampled every clock, reset included, never set from bus traffic
    always_ff @(posedge CLK) begin
        my_addr <= LISTEN_ADDRESS_SWITCHES; // RULE1
    end

    // listen address on the bus lines matches the straps
    logic addr_hit;
    assign addr_hit = listen_cmd && ((~dio_n[ADDR_BITS-1:0]) == my_addr); // RULE1

    always_ff @(posedge CLK) begin
        if (SRST) begin
            listening <= 1'b0;
        end else if (unlisten_cmd) begin
            listening <= 1'b0; // RULE14
        end else if (addr_hit) begin
            listening <= 1'b1; // RULE15
        end
    end

    assign LISTEN_ACTIVE_N = ~listening; // RULE14
    assign ADDRESSED_INDICATOR = listening; // RULE2

    // ************************************************************
    // data buffers and terminator compare
    // ************************************************************
    logic [BUS_BITS-1:0] buf_data;
    logic end_of_string;
    // buffers pass nothing unless listen_active_n is low
    assign buf_data = LISTEN_ACTIVE_N ? '0 : ~dio_n; // RULE3 RULE4
    assign end_of_string = (buf_data[CMP_BITS-1:0] == CR_CODE); // RULE6 RULE5

    // ************************************************************
    // receive strobe and acknowledge
    // ************************************************************
    logic rx_byte_strobe;
    logic valid_d;
    logic [1:0] strobe_sr;
    logic fifo_ok;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            valid_d <= 1'b0;
        end else begin
            valid_d <= byte_valid;
        end
    end

    // one strobe per new byte; a byte whose first cycle finds the fifo full is never taken
    assign rx_byte_strobe = byte_valid && !valid_d && listening && fifo_ok; // RULE8

    always_ff @(posedge CLK) begin
        if (SRST) begin
            strobe_sr <= PULSE_RST;
        end else begin
            strobe_sr <= {strobe_sr[0], rx_byte_strobe}; // RULE8
        end
    end

    // inverted second stage falls to acknowledge the byte
    assign RX_TRANSFER_DONE = ~strobe_sr[1]; // RULE9
    assign BUS_BYTE_TAKEN = strobe_sr[1];

    // ************************************************************
    // byte fifo between bus and chain
    // ************************************************************
    glsfe_fifo_if #(.WIDTH(DATA_BITS + 1)) fq();
    assign fq.in_valid = rx_byte_strobe;
    assign fq.in_data = {end_of_string, buf_data[DATA_BITS-1:0]};
    assign fifo_ok = fq.in_ready;

    glsfe_fifo #(.WIDTH(DATA_BITS + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
        .CLK(CLK),
        .SRST(SRST),
        .f(fq.fifo)
    );

    // ************************************************************
    // pulse generation and steering
    // ************************************************************
    logic [1:0] pulse_cnt;
    logic terminator_steer;
    logic busy;
    assign busy = (pulse_cnt != PULSE_RST);
    assign fq.out_ready = !busy;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            pulse_cnt <= PULSE_RST;
        end else if (!busy && fq.out_valid) begin
            pulse_cnt <= 2'(STROBE_CYCLES); // RULE10
        end else if (busy) begin
            pulse_cnt <= pulse_cnt - 2'h1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            terminator_steer <= 1'b1;
            CHAIN_DATA <= '0;
        end else if (!busy && fq.out_valid) begin
            terminator_steer <= ~fq.out_data[DATA_BITS]; // RULE7 RULE11
            CHAIN_DATA <= fq.out_data[DATA_BITS-1:0]; // RULE5
        end
    end

    // exactly one path carries each strobe
    assign CHAIN_SHIFT_PULSE = busy && terminator_steer; // RULE10 RULE19
    assign LATCH_TRANSFER_PULSE = busy && !terminator_steer; // RULE11 RULE19

    // ************************************************************
    // chain clear
    // ************************************************************
    always_ff @(posedge CLK) begin
        if (SRST) begin
            CHAIN_CLEAR_N <= 1'b0;
        end else begin
            CHAIN_CLEAR_N <= ~clear_cmd; // RULE12
        end
    end

    // ************************************************************
    // latch chain model of the backplane cards
    // ************************************************************
    logic [CHAIN_BYTES*DATA_BITS-1:0] stages;
    logic [CHAIN_BYTES*DATA_BITS-1:0] stage_in;
    logic shift_edge, load_edge;
    // act once per pulse, on its first cycle
    assign shift_edge = CHAIN_SHIFT_PULSE && pulse_cnt == 2'(STROBE_CYCLES);
    assign load_edge = LATCH_TRANSFER_PULSE && pulse_cnt == 2'(STROBE_CYCLES);
    // stage zero takes the buffered data, every later stage its predecessor
    assign stage_in = {stages[(CHAIN_BYTES-1)*DATA_BITS-1:0], CHAIN_DATA};

    genvar gs;
    generate
        for (gs = 0; gs < CHAIN_BYTES; gs++) begin : g_stage
            // clear is a level on the backplane, so it overrides a pulse in flight
            always_ff @(posedge CLK) begin
                if (SRST || !CHAIN_CLEAR_N) begin
                    stages[gs*DATA_BITS +: DATA_BITS] <= '0; // RULE18
                    RELAY_DRIVE[gs*DATA_BITS +: DATA_BITS] <= '0; // RULE18
                end else begin
                    if (shift_edge) begin
                        stages[gs*DATA_BITS +: DATA_BITS] <= stage_in[gs*DATA_BITS +: DATA_BITS]; // RULE17
                    end
                    if (load_edge) begin
                        RELAY_DRIVE[gs*DATA_BITS +: DATA_BITS] <= stages[gs*DATA_BITS +: DATA_BITS]; // RULE17
                    end
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// ==== dv/glsfe_top_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module glsfe_top_props
    import glsfe_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // watched ports
    input wire logic BUS_UNLISTEN,
    input wire logic BUS_DEVICE_CLEAR,
    input wire logic BUS_BYTE_TAKEN,
    input wire logic ADDRESSED_INDICATOR,
    input wire logic LISTEN_ACTIVE_N,
    input wire logic RX_TRANSFER_DONE,
    input wire logic CHAIN_SHIFT_PULSE,
    input wire logic LATCH_TRANSFER_PULSE,
    input wire logic CHAIN_CLEAR_N,
    input wire logic [CHAIN_BYTES*DATA_BITS-1:0] RELAY_DRIVE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    // ************************************************************
    // properties
    // ************************************************************
    chk_indicator_match: assert property (ADDRESSED_INDICATOR == !LISTEN_ACTIVE_N)
        else $error("indicator and listen state disagree");
    chk_ack_pair: assert property (RX_TRANSFER_DONE == !BUS_BYTE_TAKEN)
        else $error("ack outputs disagree");
    chk_ack_single: assert property (BUS_BYTE_TAKEN |=> !BUS_BYTE_TAKEN)
        else $error("ack longer than one cycle");
    chk_shift_width: assert property ($rose(CHAIN_SHIFT_PULSE) |=>
        CHAIN_SHIFT_PULSE ##1 !CHAIN_SHIFT_PULSE) else $error("shift pulse not two cycles");
    chk_load_width: assert property ($rose(LATCH_TRANSFER_PULSE) |=>
        LATCH_TRANSFER_PULSE ##1 !LATCH_TRANSFER_PULSE) else $error("load pulse not two cycles");
    chk_never_both: assert property (!(CHAIN_SHIFT_PULSE && LATCH_TRANSFER_PULSE))
        else $error("shift and load together");
    chk_pulse_gap: assert property ((CHAIN_SHIFT_PULSE | LATCH_TRANSFER_PULSE) [*2] |=>
        !(CHAIN_SHIFT_PULSE | LATCH_TRANSFER_PULSE)) else $error("no idle cycle after pulse");
    chk_clear_follows: assert property (BUS_DEVICE_CLEAR [*8] |-> !CHAIN_CLEAR_N)
        else $error("clear command not seen");
    chk_clear_zeroes: assert property (!CHAIN_CLEAR_N [*2] |-> RELAY_DRIVE == '0)
        else $error("relays not cleared");
    chk_unlisten_idle: assert property (BUS_UNLISTEN [*6] |-> LISTEN_ACTIVE_N)
        else $error("still listening after unlisten");
endmodule
bind glsfe_top glsfe_top_props u_props (.CLK(CLK), .SRST(SRST), .BUS_UNLISTEN(BUS_UNLISTEN),
    .BUS_DEVICE_CLEAR(BUS_DEVICE_CLEAR), .BUS_BYTE_TAKEN(BUS_BYTE_TAKEN),
    .ADDRESSED_INDICATOR(ADDRESSED_INDICATOR), .LISTEN_ACTIVE_N(LISTEN_ACTIVE_N),
    .RX_TRANSFER_DONE(RX_TRANSFER_DONE), .CHAIN_SHIFT_PULSE(CHAIN_SHIFT_PULSE),
    .LATCH_TRANSFER_PULSE(LATCH_TRANSFER_PULSE), .CHAIN_CLEAR_N(CHAIN_CLEAR_N),
    .RELAY_DRIVE(RELAY_DRIVE));
`default_nettype wire

// ==== dv/glsfe_ctrl_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module glsfe_ctrl_model
    import glsfe_pkg::*;
#(
    parameter int GAP = 4
) (
    // clock and answer
    input wire logic CLK,
    input wire logic BUS_BYTE_TAKEN,
    // bus lines driven by the controller
    output logic [BUS_BITS-1:0] BUS_DIO_N,
    output logic BUS_LISTEN_ADDR,
    output logic BUS_UNLISTEN,
    output logic BUS_DEVICE_CLEAR,
    output logic BUS_BYTE_VALID
);
    // released data lines float to the pull-up level, command lines rest low
    initial begin
        BUS_DIO_N = 8'hFF;
        {BUS_LISTEN_ADDR, BUS_UNLISTEN, BUS_DEVICE_CLEAR, BUS_BYTE_VALID} = 4'h0;
    end
    // kind 0 listen, 1 unlisten, 2 clear
    task automatic command(input logic [1:0] kind, input logic [4:0] addr);
        @(negedge CLK);
        BUS_DIO_N = {3'h7, ~addr};
        BUS_LISTEN_ADDR = (kind == 2'h0);
        BUS_UNLISTEN = (kind == 2'h1);
        BUS_DEVICE_CLEAR = (kind == 2'h2);
        repeat (8) @(negedge CLK);
        {BUS_LISTEN_ADDR, BUS_UNLISTEN, BUS_DEVICE_CLEAR} = 3'h0;
        BUS_DIO_N = 8'hFF;
        repeat (6) @(negedge CLK);
    endtask
    // holds the byte until the ack edge; a refused byte gives up after 20 cycles
    task automatic send_byte(input logic [7:0] b, output logic ok);
        int n;
        ok = 1'h0;
        @(negedge CLK);
        BUS_DIO_N = ~b;
        BUS_BYTE_VALID = 1'h1;
        for (n = 0; n < 20 && !ok; n++) begin
            @(posedge CLK);
            ok = (BUS_BYTE_TAKEN === 1'h1);
        end
        @(negedge CLK);
        BUS_BYTE_VALID = 1'h0;
        BUS_DIO_N = 8'hFF;
        repeat (GAP) @(negedge CLK);
    endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import glsfe_pkg::*;
    localparam logic [71:0] IMG = 72'h365A9C3F0F1248E7B1;
    logic CLK = 1'h0;
    logic SRST = 1'h1;
    logic [4:0] sw = 5'h0B;
    logic [7:0] dio_n;
    logic la, unl, dcl, bv, taken, ind, lan, done, shp, ldp, clrn, ok;
    logic [5:0] cdata;
    logic [71:0] relay;
    int errors = 0, n_checks = 0, cyc = 0, n_sh = 0, n_ld = 0;
    always #4 CLK = ~CLK;
    glsfe_ctrl_model ctl (.CLK(CLK), .BUS_BYTE_TAKEN(taken), .BUS_DIO_N(dio_n),
        .BUS_LISTEN_ADDR(la), .BUS_UNLISTEN(unl), .BUS_DEVICE_CLEAR(dcl), .BUS_BYTE_VALID(bv));
    glsfe_top dut (.CLK(CLK), .SRST(SRST), .LISTEN_ADDRESS_SWITCHES(sw), .BUS_DIO_N(dio_n),
        .BUS_LISTEN_ADDR(la), .BUS_UNLISTEN(unl), .BUS_DEVICE_CLEAR(dcl), .BUS_BYTE_VALID(bv),
        .BUS_BYTE_TAKEN(taken), .ADDRESSED_INDICATOR(ind), .LISTEN_ACTIVE_N(lan),
        .RX_TRANSFER_DONE(done), .CHAIN_DATA(cdata), .CHAIN_SHIFT_PULSE(shp),
        .LATCH_TRANSFER_PULSE(ldp), .CHAIN_CLEAR_N(clrn), .RELAY_DRIVE(relay));
    always @(posedge CLK) begin
        n_sh <= n_sh + int'($rose(shp));
        n_ld <= n_ld + int'($rose(ldp));
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic chk(input string what, input logic [71:0] seen, input logic [71:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_wrong_addr();
        ctl.command(2'h0, 5'h0A);
        chk("listen_n", lan, 1'h1);
        ctl.send_byte(8'h41, ok);
        chk("ack", ok, 1'h0);
        chk("shifts", n_sh, 0);
    endtask
    task automatic t_config();
        int k;
        ctl.command(2'h0, sw);
        chk("indicator", ind, 1'h1);
        chk("listen_n", lan, 1'h0);
        for (k = 0; k < CHAIN_BYTES; k++) begin
            ctl.send_byte({2'h1, IMG[71-6*k -: 6]}, ok);
            chk("ack", ok, 1'h1);
        end
        repeat (6) @(negedge CLK);
        chk("shifts", n_sh, 12);
        chk("loads", n_ld, 0);
        chk("relay", relay, 72'h0);
        chk("data", cdata, IMG[5:0]);
        ctl.send_byte(8'h0D, ok);
        repeat (6) @(negedge CLK);
        chk("loads", n_ld, 1);
        chk("shifts", n_sh, 12);
        chk("relay", relay, IMG);
        chk("data", cdata, 6'h0D);
        ctl.command(2'h1, 5'h1F);
        chk("listen_n", lan, 1'h1);
        chk("indicator", ind, 1'h0);
        ctl.send_byte(8'h42, ok);
        chk("ack", ok, 1'h0);
    endtask
    task automatic t_clear();
        fork
            ctl.command(2'h2, 5'h00);
            begin
                repeat (8) @(negedge CLK);
                chk("clear_n", clrn, 1'h0);
                chk("relay", relay, 72'h0);
            end
        join
        chk("clear_n", clrn, 1'h1);
    endtask
    initial begin
        repeat (3) @(negedge CLK);
        chk("clear_n", clrn, 1'h0);
        chk("listen_n", lan, 1'h1);
        chk("done", done, 1'h1);
        SRST = 1'h0;
        repeat (8) @(negedge CLK);
        chk("clear_n", clrn, 1'h1);
        t_wrong_addr();
        t_config();
        t_clear();
        end_of_test();
    end
endmodule
`default_nettype wire
